// file: tb/bus_masters.sv
`timescale 1ns/1ps
// ==============================================================
// Processor and DMA masters on the shared bus
module bus_masters
  import memctl_pkg::*;
(
  input  wire logic   clk,       // Bus clock
  input  wire logic   abort,     // Abort to all masters
  output logic        dma_req,   // DMA request
  output logic [31:0] dma_addr,  // DMA address
  output logic        dma_write, // DMA write
  output xfer_size_t  dma_size,  // DMA size
  output logic        cpu_req,   // Processor request
  output logic [31:0] cpu_addr,  // Processor address
  output logic        cpu_write, // Processor write
  output logic        cpu_fetch, // Processor fetch
  output xfer_size_t  cpu_size   // Processor size
);
  logic cpu_abort_seen; // Abort as the processor took it
  initial begin
    {dma_req, cpu_req, dma_write, cpu_write, cpu_fetch} = 5'h00;
    {dma_addr, cpu_addr} = 64'h0;
    dma_size = SIZE_BYTE;
    cpu_size = SIZE_BYTE;
    cpu_abort_seen = 1'b0;
  end
  // DMA access; its abort input is left unread
  task automatic dma_go(input logic [31:0] a, input logic w,
                        input xfer_size_t s);
    @(posedge clk);
    dma_req <= 1'b1;
    dma_addr <= a;
    dma_write <= w;
    dma_size <= s;
    @(posedge clk);
    dma_req <= 1'b0;
    dma_addr <= ~a;  // Released bus shows garbage, not the old value
    #1;
  endtask
  // Processor access, abort sampled one cycle after its request, granted or not
  task automatic cpu_go(input logic [31:0] a, input logic w, input logic f,
                        input xfer_size_t s);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    cpu_write <= w;
    cpu_fetch <= f;
    cpu_size <= s;
    @(posedge clk);
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    #1 cpu_abort_seen = abort;
  endtask
endmodule

// file: tb/memctl_monitor.sv
`timescale 1ns/1ps
// ==============================================================
// Port checks for the memory controller
module memctl_monitor
  import memctl_pkg::*;
#(
  parameter int FLASH_AW = 18,  // Flash byte address bits
  parameter int SRAM_AW  = 16   // SRAM byte address bits
) (
  input wire logic               clk,         // Bus clock
  input wire logic               srst,        // Sync reset
  input wire logic               dma_req,     // DMA request
  input wire logic [31:0]        dma_addr,    // DMA address
  input wire memctl_pkg::xfer_size_t dma_size, // DMA size
  input wire logic               cpu_req,     // Processor request
  input wire logic               dma_gnt,     // DMA grant
  input wire logic               cpu_gnt,     // Processor grant
  input wire logic               abort,       // Abort pulse
  input wire logic               mem_valid,   // Accepted pulse
  input wire memctl_pkg::target_t mem_sel,    // Selected memory
  input wire logic [19:0]        mem_offset,  // Aliased offset
  input wire logic               remap_state, // Remap state
  input wire logic [7:0]         reg_addr,    // Register address
  input wire logic [31:0]        reg_wdata,   // Register data
  input wire logic               reg_wr,      // Register write
  input wire logic               reg_rd,      // Register read
  input wire logic [31:0]        reg_rdata    // Register read data
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Misaligned DMA word access, cancelled one cycle on
  sequence dma_word_misal;
    dma_req && dma_size == SIZE_WORD && dma_addr[1:0] != 2'h0;
  endsequence
  dma_prio_a: assert property (dma_req |-> dma_gnt && !cpu_gnt)
    else $error("processor granted while DMA requests");
  one_answer_a: assert property ((dma_req || cpu_req) |=> abort != mem_valid)
    else $error("access not answered exactly once");
  misal_cancel_a: assert property (dma_word_misal |=> abort && !mem_valid)
    else $error("misaligned word not aborted");
  undef_region_a: assert property (
    dma_req && dma_addr[31:28] == 4'h5 |=> abort)
    else $error("undefined region not aborted");
  quiet_win_a: assert property (
    dma_req && dma_addr[31:20] == 12'h003 && dma_size == SIZE_BYTE
    |=> mem_valid && !abort)
    else $error("quiet window aborted");
  sram_alias_a: assert property (
    dma_req && dma_addr[31:20] == 12'h002
    |=> mem_offset[19:SRAM_AW] == '0)
    else $error("SRAM offset not aliased");
  boot_flash_a: assert property (
    dma_req && dma_addr[31:20] == 12'h000 && dma_size == SIZE_BYTE
    && !remap_state && !reg_wr |=> mem_sel == TGT_FLASH)
    else $error("area zero not flash before remap");
  remap_flip_a: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0]
    |=> remap_state != $past(remap_state))
    else $error("remap did not toggle");
  remap_hold_a: assert property (reg_wr && reg_addr == 8'h00 && !reg_wdata[0]
    |=> $stable(remap_state))
    else $error("remap changed on zero write");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read answer");
endmodule

bind memory_controller memctl_monitor #(.FLASH_AW(FLASH_AW),
  .SRAM_AW(SRAM_AW)) mon (.clk, .srst, .dma_req, .dma_addr, .dma_size,
  .cpu_req, .dma_gnt, .cpu_gnt, .abort, .mem_valid, .mem_sel, .mem_offset,
  .remap_state, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

// file: tb/memory_controller_tb.sv
`timescale 1ns/1ps
// ==============================================================
// Self-checking bench for the memory controller
module memory_controller_tb;
  import memctl_pkg::*;
  logic clk = 1'b0, srst = 1'b1;          // Clock and reset
  logic dma_req, dma_write, cpu_req, cpu_write, cpu_fetch; // Masters
  logic [31:0] dma_addr, cpu_addr;        // Master addresses
  xfer_size_t dma_size, cpu_size, mem_size; // Sizes
  logic dma_gnt, cpu_gnt, abort, mem_valid, mem_write, remap_state;
  target_t mem_sel;                       // Selected memory
  logic [19:0] mem_offset;                // Aliased offset
  logic [7:0] reg_addr = 8'h00;           // Register port
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, a, e;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cpu, w, f, rm;
  xfer_size_t s;
  target_t tt;                            // Expected target
  int checked = 0, miscompares = 0;
  memory_controller DUT (
    .clk        (clk),        .srst      (srst),
    .dma_req    (dma_req),    .dma_addr  (dma_addr),
    .dma_write  (dma_write),  .dma_size  (dma_size),
    .cpu_req    (cpu_req),    .cpu_addr  (cpu_addr),
    .cpu_write  (cpu_write),  .cpu_fetch (cpu_fetch),
    .cpu_size   (cpu_size),   .dma_gnt   (dma_gnt),
    .cpu_gnt    (cpu_gnt),    .abort     (abort),
    .mem_sel    (mem_sel),    .mem_valid (mem_valid),
    .mem_offset (mem_offset), .mem_write (mem_write),
    .mem_size   (mem_size),   .remap_state (remap_state),
    .reg_addr   (reg_addr),   .reg_wdata (reg_wdata),
    .reg_wr     (reg_wr),     .reg_rd    (reg_rd),
    .reg_rdata  (reg_rdata)
  );
  bus_masters M (.clk, .abort, .dma_req, .dma_addr, .dma_write, .dma_size,
    .cpu_req, .cpu_addr, .cpu_write, .cpu_fetch, .cpu_size);
  initial forever #2.5 clk = ~clk;
  // Verdict and end of run
  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rw(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rr(input logic [7:0] ad, output logic [31:0] rd);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // Status expected after one abort, zero when none is due
  function automatic logic [31:0] exp_stat(logic [31:0] ad, xfer_size_t sz,
                                           logic c, logic wr, logic fe);
    logic u, m;
    logic [1:0] t;
    u = !(ad[31:28] inside {4'h0, 4'hF}) || (ad[31:28] == 4'h0
        && ad[27:20] > 8'h03);
    m = !(c && fe && !wr) && ((sz == SIZE_WORD && ad[1:0] != 2'h0)
        || (sz == SIZE_HALF && ad[0]));
    t = wr ? 2'h1 : (c && fe) ? 2'h2 : 2'h0;
    return (u || m) ? {6'h0, c, !c, 6'h0, c, !c, 4'h0, t, sz, 6'h0, m, u}
                    : 32'h0;
  endfunction
  function automatic target_t exp_tgt(logic [31:0] ad, logic r);
    if (ad[31:28] == 4'hF) return TGT_PERIPH;
    case (ad[21:20])
      2'h0: return r ? TGT_SRAM : TGT_FLASH;
      2'h1: return TGT_FLASH;
      2'h2: return TGT_SRAM;
      default: return TGT_QUIET;
    endcase
  endfunction
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    void'($urandom(29854));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rm = 1'b0;
    check("remap", remap_state, 0);
    rr(8'h04, d); check("status", d, 0);
    rr(8'h08, d); check("abort_addr", d, 0);
    rr(8'h0C, d); check("unmapped", d, 0);
    rr(8'h00, d); check("remap_read", d, 0);
    rw(8'h00, 32'hFFFF_FFFE); check("remap", remap_state, rm);
    // Random traffic across regions, windows, sizes and masters
    repeat (300) begin
      cpu = 1'($urandom_range(1));
      a = $urandom;
      if ($urandom_range(3) != 0) a[31:28] = $urandom_range(1) ? 4'h0 : 4'hF;
      a[27:20] = 8'($urandom_range(4));
      if ($urandom_range(7) == 0) a[27:20] = 8'($urandom);
      s = xfer_size_t'($urandom_range(2));
      w = 1'($urandom_range(1));
      f = cpu & 1'($urandom_range(1));
      if ($urandom_range(7) == 0) begin
        d = $urandom;
        rm ^= d[0];
        rw(8'h00, d); check("remap", remap_state, rm);
      end
      if (cpu) M.cpu_go(a, w, f, s);
      else M.dma_go(a, w, s);
      e = exp_stat(a, s, cpu, w, f);
      check("abort", abort, e != 0);
      if (cpu) check("cpu_abort", M.cpu_abort_seen, e != 0);
      check("mem_valid", mem_valid, e == 0);
      check("mem_write", mem_write, e == 0 && w);
      check("mem_size", 32'(mem_size), 32'(s));
      if (e == 0) begin
        tt = exp_tgt(a, rm);
        check("mem_sel", 32'(mem_sel), 32'(tt));
        // Mask from the memory sizes, not from the design's choice
        d = (32'h1 << (tt == TGT_FLASH ? 18 : 16)) - 32'h1;
        if (tt inside {TGT_FLASH, TGT_SRAM})
          check("offset", mem_offset, a & d);
      end else begin
        rr(8'h08, d); check("abort_addr", d, a);
        rr(8'h04, d); check("status", d, e);
      end
    end
    // Two aborts unread: both sticky, fields from the last one
    M.dma_go(32'h5000_0000, 1'b0, SIZE_BYTE);
    M.cpu_go(32'h0020_0002, 1'b1, 1'b0, SIZE_WORD);
    e = exp_stat(32'h0020_0002, SIZE_WORD, 1'b1, 1'b1, 1'b0);
    rr(8'h04, d); check("status", d, e | 32'h0100_0000);
    rr(8'h04, d); check("status", d, e & 32'hFCFF_FFFF);
    rr(8'h08, d); check("abort_addr", d, 32'h0020_0002);
    // Both masters at once: DMA wins, its fault is recorded
    fork
      M.dma_go(32'h2000_0000, 1'b0, SIZE_WORD);
      M.cpu_go(32'h0010_0000, 1'b0, 1'b0, SIZE_WORD);
    join
    check("abort", abort, 1);
    e = exp_stat(32'h2000_0000, SIZE_WORD, 1'b0, 1'b0, 1'b0);
    rr(8'h04, d); check("status", d, e);
    // Mid-run reset: remap and abort record go back to zero
    if (!rm) rw(8'h00, 32'h0000_0001);
    check("remap", remap_state, 1);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rm = 1'b0;
    #1;
    check("remap", remap_state, rm);
    rr(8'h04, d); check("status", d, 0);
    rr(8'h08, d); check("abort_addr", d, 0);
    test_done();
  end
endmodule

// file: verilog/addr_decoder.sv
`timescale 1ns/1ps
`include "memctl_cfg.svh"
// Two-level decoder with boot-area remap and misalignment check.
module addr_decoder
  import memctl_pkg::*;
#(
  parameter int FLASH_AW = 18,  // Flash size as byte address bits
  parameter int SRAM_AW  = 16   // SRAM size as byte address bits
) (
  input  wire logic [31:0]    addr,       // Granted master address
  input  wire memctl_pkg::xfer_size_t size, // Transfer size
  input  wire logic           fetch,      // Instruction fetch
  input  wire logic           from_cpu,   // Access is from processor
  input  wire logic           remapped,   // Remap state
  output memctl_pkg::target_t target,     // Selected memory
  output logic [19:0]         offset,     // Offset inside memory
  output logic                undef,      // Undefined address
  output logic                misal       // Misaligned address
);
  // ==========================================================
  // Region and window fields
  logic [3:0] region;  // Top four address bits
  logic [7:0] window;  // Next eight bits inside internal area
  logic       check;   // Alignment check applies
  assign region = addr[31:28];  // R02
  assign window = addr[27:20];  // R04

  // ==========================================================
  // Target selection
  // Area 0 follows remap; originals stay reachable too
  always_comb begin
    target = TGT_NONE;
    if (region == `REGION_PERIPH) begin
      target = TGT_PERIPH;  // R02
    end else if (region == `REGION_INTMEM) begin
      unique case (window)
        `WIN_AREA0:   target = remapped ? TGT_SRAM : TGT_FLASH;  // R08
        `WIN_FLASH:   target = TGT_FLASH;  // R09
        `WIN_SRAM:    target = TGT_SRAM;   // R09
        `WIN_NOABORT: target = TGT_QUIET;  // R07
        default:      target = TGT_NONE;   // R06
      endcase
    end
  end
  assign undef = (target == TGT_NONE);  // R03 R06

  // ==========================================================
  // Aliasing: drop bits above the memory size
  always_comb begin
    offset = addr[19:0];
    if (target == TGT_FLASH) begin
      offset = addr[19:0] & 20'((1 << FLASH_AW) - 1);  // R05
    end else if (target == TGT_SRAM) begin
      offset = addr[19:0] & 20'((1 << SRAM_AW) - 1);   // R05
    end
  end

  // ==========================================================
  // Misalignment; processor fetches exempt
  assign check = ~(fetch & from_cpu);  // R18
  assign misal = check &
                 (((size == SIZE_WORD) & (addr[1:0] != 2'h0)) |
                  ((size == SIZE_HALF) & addr[0]));  // R17
endmodule

// file: verilog/bus_arbiter.sv
`timescale 1ns/1ps
// Fixed-priority two-master arbiter; DMA always wins.
module bus_arbiter (
  input  wire logic dma_req,   // DMA master requests
  input  wire logic cpu_req,   // Processor requests
  output logic      dma_gnt,   // DMA owns the bus
  output logic      cpu_gnt    // Processor owns the bus
);
  // ==========================================================
  // Grant logic
  // Hard-wired: no fairness, the processor can starve
  assign dma_gnt = dma_req;             // R01
  assign cpu_gnt = cpu_req & ~dma_req;  // R01
endmodule

// file: verilog/memctl_cfg.svh
`ifndef MEMCTL_CFG_SVH
`define MEMCTL_CFG_SVH
// Register offsets (byte addresses on the register port)
`define OFS_REMAP_CTRL   8'h00
`define OFS_ABORT_STATUS 8'h04
`define OFS_ABORT_ADDR   8'h08
// Remap control field
`define BIT_REMAP_TOGGLE 0
// Abort status field positions
`define BIT_UNDEF        0
`define BIT_MISAL        1
`define LSB_SIZE         8
`define LSB_TYPE         10
`define BIT_SRC_DMA      16
`define BIT_SRC_CPU      17
`define BIT_STICKY_DMA   24
`define BIT_STICKY_CPU   25
// Top-level region codes (address bits 31:28)
`define REGION_INTMEM    4'h0
`define REGION_PERIPH    4'hF
// Internal memory windows (address bits 27:20)
`define WIN_AREA0        8'h00
`define WIN_FLASH        8'h01
`define WIN_SRAM         8'h02
`define WIN_NOABORT      8'h03
// Reset values
`define ABORT_ADDR_RST   32'h0000_0000
`define ABORT_STAT_RST   32'h0000_0000
`endif

// file: verilog/memctl_pkg.sv
package memctl_pkg;
  // Transfer size as carried on the bus and stored on abort
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2,
    SIZE_RSVD = 2'h3
  } xfer_size_t;
  // Access type as stored on abort
  typedef enum logic [1:0] {
    TYPE_DREAD  = 2'h0,
    TYPE_DWRITE = 2'h1,
    TYPE_FETCH  = 2'h2,
    TYPE_RSVD   = 2'h3
  } xfer_type_t;
  // Memory target selected by the decoder
  typedef enum logic [2:0] {
    TGT_FLASH  = 3'h0,
    TGT_SRAM   = 3'h1,
    TGT_PERIPH = 3'h2,
    TGT_QUIET  = 3'h3,
    TGT_NONE   = 3'h4
  } target_t;
endpackage

// file: verilog/memory_controller.sv
`timescale 1ns/1ps
`include "memctl_cfg.svh"
// What this block does
// R01 - DMA master beats processor, fixed priority
// R02 - Top four address bits pick region
// R03 - Undefined top regions answer abort
// R04 - Eight more bits pick 1-Mbyte windows
// R05 - Small memories alias across whole window
// R06 - Unallocated internal window answers abort
// R07 - Window 0x003xxxxx never aborts as undefined; misaligned word or halfword accesses there still abort
// R08 - Area 0 holds flash, SRAM after remap
// R09 - Area 0 memory stays at original window
// R10 - Writing one toggles remap; reset unmapped
// R11 - Little-endian byte order only
// R12 - Abort goes to every master
// R13 - Only busy processor heeds abort
// R14 - Capture full faulting address on abort
// R15 - Record size, type, cause, source
// R16 - Sticky per-master abort flags, clear on read
// R17 - Misaligned word or halfword aborts, cancelled
// R18 - Processor fetches skip alignment check
// R19 - Size and type field encodings fixed
// R20 - Source flags one bit per master
// R21 - New abort overwrites captured fields
module memory_controller
  import memctl_pkg::*;
#(
  parameter int FLASH_AW = 18,  // Flash byte address bits
  parameter int SRAM_AW  = 16   // SRAM byte address bits
) (
  input  wire logic               clk,          // System bus clock
  input  wire logic               srst,         // Sync reset, high
  // DMA master request
  input  wire logic               dma_req,      // Requests bus
  input  wire logic [31:0]        dma_addr,     // Address
  input  wire logic               dma_write,    // Write when high
  input  wire memctl_pkg::xfer_size_t dma_size, // Transfer size
  // Processor master request
  input  wire logic               cpu_req,      // Requests bus
  input  wire logic [31:0]        cpu_addr,     // Address
  input  wire logic               cpu_write,    // Write when high
  input  wire logic               cpu_fetch,    // Instruction fetch
  input  wire memctl_pkg::xfer_size_t cpu_size, // Transfer size
  // Bus result
  output logic                    dma_gnt,      // DMA owns bus
  output logic                    cpu_gnt,      // Processor owns bus
  output logic                    abort,        // Abort to all masters
  output memctl_pkg::target_t     mem_sel,      // Selected memory
  output logic                    mem_valid,    // Access goes ahead
  output logic [19:0]             mem_offset,   // Aliased offset
  output logic                    mem_write,    // Write strobe
  output memctl_pkg::xfer_size_t  mem_size,     // Size to memory
  output logic                    remap_state,  // Area 0 holds SRAM
  // Register port
  input  wire logic [7:0]         reg_addr,     // Byte address
  input  wire logic [31:0]        reg_wdata,    // Write data
  input  wire logic               reg_wr,       // Write strobe
  input  wire logic               reg_rd,       // Read strobe
  output logic [31:0]             reg_rdata     // Read data, next cycle
);
  // ==========================================================
  // Arbitration
  logic any_gnt;  // Some master owns the bus this cycle
  bus_arbiter u_arb (
    .dma_req (dma_req),
    .cpu_req (cpu_req),
    .dma_gnt (dma_gnt),
    .cpu_gnt (cpu_gnt)
  );
  assign any_gnt = dma_gnt | cpu_gnt;

  // ==========================================================
  // Granted-master mux
  // Only the processor fetches; DMA traffic is always data
  logic [31:0] sel_addr;   // Address of the owner
  logic        sel_write;  // Write of the owner
  logic        sel_fetch;  // Fetch of the owner
  xfer_size_t  sel_size;   // Size of the owner
  assign sel_addr  = dma_gnt ? dma_addr  : cpu_addr;   // R01
  assign sel_write = dma_gnt ? dma_write : cpu_write;
  assign sel_fetch = cpu_gnt & cpu_fetch & ~cpu_write;
  assign sel_size  = dma_gnt ? dma_size  : cpu_size;

  // ==========================================================
  // Decode
  logic        remapped;   // Remap toggle state
  target_t     dec_tgt;    // Decoder target
  logic [19:0] dec_off;    // Aliased offset
  logic        dec_undef;  // Undefined address
  logic        dec_misal;  // Misaligned address
  addr_decoder #(
    .FLASH_AW (FLASH_AW),
    .SRAM_AW  (SRAM_AW)
  ) u_dec (
    .addr     (sel_addr),
    .size     (sel_size),
    .fetch    (sel_fetch),
    .from_cpu (cpu_gnt),
    .remapped (remapped),
    .target   (dec_tgt),
    .offset   (dec_off),
    .undef    (dec_undef),
    .misal    (dec_misal)
  );

  // ==========================================================
  // Abort event
  logic abort_now;  // Faulting access in this cycle
  assign abort_now = any_gnt & (dec_undef | dec_misal);  // R03 R06 R17

  // ==========================================================
  // Bus outputs
  // Registered one cycle after the access; no big-endian swap
  // exists, offsets pass straight through
  always_ff @(posedge clk) begin
    if (srst) begin
      abort      <= 1'b0;
      mem_valid  <= 1'b0;
      mem_sel    <= TGT_NONE;
      mem_offset <= 20'h0_0000;
      mem_write  <= 1'b0;
      mem_size   <= SIZE_BYTE;
    end else begin
      abort      <= abort_now;                 // R12
      mem_valid  <= any_gnt & ~abort_now;      // R17
      mem_sel    <= dec_tgt;
      mem_offset <= dec_off;                   // R11
      mem_write  <= any_gnt & ~abort_now & sel_write;
      mem_size   <= sel_size;
    end
  end

  // ==========================================================
  // Register decode
  logic hit_remap;   // Remap control addressed
  logic hit_status;  // Abort status addressed
  logic hit_addr;    // Abort address addressed
  assign hit_remap  = (reg_addr == `OFS_REMAP_CTRL);
  assign hit_status = (reg_addr == `OFS_ABORT_STATUS);
  assign hit_addr   = (reg_addr == `OFS_ABORT_ADDR);

  logic toggle;      // Write of one to the toggle bit
  logic stat_read;   // Abort status is being read
  assign toggle    = reg_wr & hit_remap &
                     reg_wdata[`BIT_REMAP_TOGGLE];  // R10
  assign stat_read = reg_rd & hit_status;

  // ==========================================================
  // Remap state
  always_ff @(posedge clk) begin
    if (srst) begin
      remapped <= 1'b0;          // R10
    end else if (toggle) begin
      remapped <= ~remapped;     // R10
    end
  end
  assign remap_state = remapped;

  // ==========================================================
  // Abort record
  logic [31:0] abt_addr;    // Last faulting address
  xfer_size_t  abt_size;    // Last faulting size
  xfer_type_t  abt_type;    // Last faulting type
  logic        abt_undef;   // Last cause undefined
  logic        abt_misal;   // Last cause misaligned
  logic        abt_dma;     // Last source DMA
  logic        abt_cpu;     // Last source processor
  xfer_type_t  cur_type;    // Type of current access
  assign cur_type = sel_fetch ? TYPE_FETCH :
                    (sel_write ? TYPE_DWRITE : TYPE_DREAD);  // R19

  // Overwrites on each abort, latest wins
  always_ff @(posedge clk) begin
    if (srst) begin
      abt_addr  <= `ABORT_ADDR_RST;
      abt_size  <= SIZE_BYTE;
      abt_type  <= TYPE_DREAD;
      abt_undef <= 1'b0;
      abt_misal <= 1'b0;
      abt_dma   <= 1'b0;
      abt_cpu   <= 1'b0;
    end else if (abort_now) begin
      abt_addr  <= sel_addr;   // R14 R21
      abt_size  <= sel_size;   // R15 R19
      abt_type  <= cur_type;   // R15
      abt_undef <= dec_undef;  // R15
      abt_misal <= dec_misal;  // R15
      abt_dma   <= dma_gnt;    // R20
      abt_cpu   <= cpu_gnt;    // R20
    end
  end

  // ==========================================================
  // Sticky per-master flags
  // Set wins over the read clear so no abort is lost
  logic sticky_dma;  // DMA aborted since last read
  logic sticky_cpu;  // Processor aborted since last read
  always_ff @(posedge clk) begin
    if (srst) begin
      sticky_dma <= 1'b0;
      sticky_cpu <= 1'b0;
    end else begin
      sticky_dma <= (abort_now & dma_gnt) |
                    (sticky_dma & ~stat_read);  // R16
      sticky_cpu <= (abort_now & cpu_gnt) |
                    (sticky_cpu & ~stat_read);  // R16
    end
  end

  // ==========================================================
  // Read data
  logic [31:0] status_word;  // Abort status assembled
  always_comb begin
    status_word = `ABORT_STAT_RST;
    status_word[`BIT_UNDEF]            = abt_undef;
    status_word[`BIT_MISAL]            = abt_misal;
    status_word[`LSB_SIZE +: 2]        = abt_size;
    status_word[`LSB_TYPE +: 2]        = abt_type;
    status_word[`BIT_SRC_DMA]          = abt_dma;
    status_word[`BIT_SRC_CPU]          = abt_cpu;
    status_word[`BIT_STICKY_DMA]       = sticky_dma;
    status_word[`BIT_STICKY_CPU]       = sticky_cpu;
  end

  logic [31:0] next_rdata;  // Selected read value
  // Remap control is write-only, unmapped reads give zero
  assign next_rdata = hit_status ? status_word :
                      (hit_addr ? abt_addr : 32'h0000_0000);

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule
